// File: design/eeprom_read_controller.sv
// two-wire bus controller issuing current, sequential and random reads
// assumes it is the only scl driver; scl comes from a divider of clk
`timescale 1ns/10ps
module eeprom_read_controller #(
  parameter int ADDR_W = eeprom_rd_pkg::WORD_ADDR_W,
  parameter int CNT_W = 8,
  parameter int QUARTER_CYC = eeprom_rd_pkg::SCL_QUARTER_CYC
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic req_i,
  input wire logic random_i,
  input wire logic [ADDR_W-1:0] word_addr_i,
  input wire logic [2:0] dev_sel_i,
  input wire logic [CNT_W-1:0] count_i,
  output logic busy_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic done_o,
  output logic nack_o,
  ee_link_if.controller link
);

  typedef enum logic [3:0] {
    h_idle,
    h_start1,
    h_adw,
    h_ahi,
    h_alo,
    h_start2,
    h_adr,
    h_rd,
    h_stop
  } hseq_type;

  hseq_type seq;
  hseq_type next_seq;
  logic sync1;
  logic sync2;
  logic sync3;
  logic lvl;
  logic next_lvl;
  logic [15:0] qcnt;
  logic [15:0] next_qcnt;
  logic [1:0] qi;
  logic [1:0] next_qi;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [CNT_W-1:0] remain;
  logic [CNT_W-1:0] next_remain;
  logic [ADDR_W-1:0] waddr;
  logic [ADDR_W-1:0] next_waddr;
  logic [2:0] sel;
  logic [2:0] next_sel;
  logic rnd;
  logic next_rnd;
  logic scl;
  logic next_scl;
  logic oe;
  logic next_oe;
  logic ack_seen;
  logic next_ack_seen;
  logic [7:0] rd_data;
  logic [7:0] next_rd_data;
  logic rd_valid;
  logic next_rd_valid;
  logic done;
  logic next_done;
  logic nack;
  logic next_nack;

  logic is_tx;
  logic op_start;
  logic op_stop;
  logic bit_drv;
  logic last_byte;
  logic [15:0] addr16;

  assign is_tx = seq inside {h_adw, h_ahi, h_alo, h_adr};
  assign op_start = (seq == h_start1) || (seq == h_start2);
  assign op_stop = (seq == h_stop);
  assign last_byte = (remain == CNT_W'(1));
  assign addr16 = 16'(waddr);
  // [R3] [R6] ack every byte except the last one
  assign bit_drv = is_tx ?
    (bit_idx != eeprom_rd_pkg::ACK_BIT) & ~shift[7] :
    (bit_idx == eeprom_rd_pkg::ACK_BIT) & ~last_byte;

  //////////////////////////////////////////////////////////////////////
  // every op is four quarters: scl low, set sda, scl high, sample or
  // move sda; start and stop preset sda with scl low, then flip it while scl is high

  always_comb begin
    next_lvl = (sync2 == sync3) ? sync3 : lvl;
    next_seq = seq;
    next_qcnt = 16'h0000;
    next_qi = qi;
    next_bit_idx = bit_idx;
    next_shift = shift;
    next_remain = remain;
    next_waddr = waddr;
    next_sel = sel;
    next_rnd = rnd;
    next_scl = scl;
    next_oe = oe;
    next_ack_seen = ack_seen;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    next_done = 1'b0;
    next_nack = nack;
    if (seq == h_idle) begin
      if (req_i) begin
        next_seq = h_start1;
        next_qi = 2'h0;
        next_waddr = word_addr_i;
        next_sel = dev_sel_i;
        next_rnd = random_i;
        next_remain = (count_i == '0) ? CNT_W'(1) : count_i;
        next_nack = 1'b0;
      end
    end else begin
      if (qcnt != 16'(QUARTER_CYC - 1)) begin
        next_qcnt = qcnt + 16'h0001;
      end
      if (qcnt == 16'h0000) begin
        case (qi)
          2'h0: next_scl = 1'b0;
          2'h1: next_oe = op_start ? 1'b0 : (op_stop | bit_drv);
          2'h2: next_scl = 1'b1;
          default: begin
            if (op_start) begin
              next_oe = 1'b1;
            end else if (op_stop) begin
              next_oe = 1'b0;
            end else if (bit_idx == eeprom_rd_pkg::ACK_BIT) begin
              next_ack_seen = ~lvl;
            end else begin
              next_shift = {shift[6:0], is_tx ? 1'b0 : lvl};
            end
          end
        endcase
      end
      if (qcnt == 16'(QUARTER_CYC - 1)) begin
        next_qi = qi + 2'h1;
        if (qi == 2'h3) begin
          next_bit_idx = 4'h0;
          case (seq)
            h_start1: begin
              // [R7] random read opens with a write-direction word
              next_seq = rnd ? h_adw : h_adr;
              next_shift = {eeprom_rd_pkg::DEV_TYPE_CODE, sel, ~rnd};
            end
            h_start2: begin
              next_seq = h_adr;
              next_shift = {eeprom_rd_pkg::DEV_TYPE_CODE, sel, 1'b1};
            end
            h_stop: begin
              next_seq = h_idle;
              next_done = 1'b1;
            end
            default: begin
              if (bit_idx != eeprom_rd_pkg::ACK_BIT) begin
                next_bit_idx = bit_idx + 4'h1;
              end else if (is_tx && !ack_seen) begin
                next_nack = 1'b1;
                next_seq = h_stop;
              end else if (seq == h_adw) begin
                // [R14] word address as high then low byte
                next_seq = h_ahi;
                next_shift = addr16[15:8];
              end else if (seq == h_ahi) begin
                next_seq = h_alo;
                next_shift = addr16[7:0];
              end else if (seq == h_alo) begin
                // [R9] no data byte: repeated start instead
                next_seq = h_start2;
              end else if (seq == h_adr) begin
                next_seq = h_rd;
              end else begin
                // [R4] deliver the byte, go on while bytes remain
                next_rd_data = shift;
                next_rd_valid = 1'b1;
                next_remain = remain - CNT_W'(1);
                next_seq = last_byte ? h_stop : h_rd;
              end
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1 <= eeprom_rd_pkg::HOST_LVL_RESET;
      sync2 <= eeprom_rd_pkg::HOST_LVL_RESET;
      sync3 <= eeprom_rd_pkg::HOST_LVL_RESET;
      lvl <= eeprom_rd_pkg::HOST_LVL_RESET;
      seq <= h_idle;
      qcnt <= 16'h0000;
      qi <= 2'h0;
      bit_idx <= 4'h0;
      shift <= 8'h00;
      remain <= '0;
      waddr <= '0;
      sel <= 3'h0;
      rnd <= 1'b0;
      scl <= 1'b1;
      oe <= 1'b0;
      ack_seen <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
    end else if (ce_i) begin
      sync1 <= link.sda;
      sync2 <= sync1;
      sync3 <= sync2;
      lvl <= next_lvl;
      seq <= next_seq;
      qcnt <= next_qcnt;
      qi <= next_qi;
      bit_idx <= next_bit_idx;
      shift <= next_shift;
      remain <= next_remain;
      waddr <= next_waddr;
      sel <= next_sel;
      rnd <= next_rnd;
      scl <= next_scl;
      oe <= next_oe;
      ack_seen <= next_ack_seen;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      done <= next_done;
      nack <= next_nack;
    end
  end

  // open drain sda, scl driven push-pull by this sole controller
  assign link.scl = scl;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = oe;
  assign busy_o = (seq != h_idle);
  assign rd_data_o = rd_data;
  assign rd_valid_o = rd_valid;
  assign done_o = done;
  assign nack_o = nack;

endmodule

// File: design/eeprom_rd_pkg.sv
// constants shared by the read-side serial eeprom target and controller
// assumes a 100 MHz system clock on both ends and one shared link
//
// Contract
// [R1] target acks matching read address on clock 9
// [R2] target shifts out byte, then bumps counter
// [R3] controller acks to ask for next byte
// [R4] streaming continues while controller keeps acking
// [R5] counter wraps from top address to zero
// [R6] controller ends read with nack then stop
// [R7] random read starts with dummy write address
// [R8] target acks dummy write, loads word address
// [R9] controller sends repeated start, no write data
// [R10] new start abandons the pending dummy write
// [R11] respond only to 1010 plus chip-select match
// [R12] counter keeps last address plus one
// [R13] twelve-bit word address selects array byte
// [R14] word address goes as two acked bytes
// [R15] ignore high address bits, release, stop idles
// [R16] change sda after scl falls, sample rising
package eeprom_rd_pkg;

  //////////////////////////////////////////////////////////////////////
  // clock and link timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 2500;
  // a quarter of the scl period is a least time: round up
  localparam int SCL_QUARTER_CYC =
    (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  //////////////////////////////////////////////////////////////////////
  // addressing
  localparam int WORD_ADDR_W = 12;
  localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  //////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [11:0] ADDR_CNT_RESET = 12'h000;
  // chip-select bits low, scl and sda idle high
  localparam logic [4:0] TGT_LVL_RESET = 5'h03;
  localparam logic HOST_LVL_RESET = 1'b1;

endpackage

// File: design/ee_link_if.sv
// the two-wire link between the eeprom target and its controller
// assumes one controller driving scl and a pull-up on sda
`timescale 1ns/10ps
interface ee_link_if;
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // wired-and of two open-drain drivers over a pull-up
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport target (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport controller (
    output scl,
    input sda,
    output host_sda_o,
    output host_sda_oe
  );
endinterface

// File: design/eeprom_read_target.sv
// read-side protocol logic of the serial eeprom target
// assumes scl and sda arrive unsynchronised; the array is filled
// through the load port, there is no programming path
`timescale 1ns/10ps
module eeprom_read_target #(
  parameter int ADDR_W = eeprom_rd_pkg::WORD_ADDR_W
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [2:0] chip_select_address_pins_i,
  input wire logic load_en_i,
  input wire logic [ADDR_W-1:0] load_addr_i,
  input wire logic [7:0] load_data_i,
  output logic [ADDR_W-1:0] addr_cnt_o,
  output logic active_o,
  ee_link_if.target link
);

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_ack,
    st_whi,
    st_wlo,
    st_tx,
    st_hack
  } state_type;

  //////////////////////////////////////////////////////////////////////
  // storage and state

  logic [7:0] mem [0:(1<<ADDR_W)-1];

  // pin synchronisers: {chip select, scl, sda}
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [4:0] lvl;
  logic [4:0] next_lvl;
  logic [4:0] stable;

  state_type state;
  state_type next_state;
  state_type ret;
  state_type next_ret;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [ADDR_W-1:0] addr_cnt;
  logic [ADDR_W-1:0] next_addr_cnt;
  logic [7:0] addr_hi;
  logic [7:0] next_addr_hi;
  logic drive;
  logic next_drive;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] rx_byte;
  logic [7:0] mem_byte;
  logic cs_ok;
  logic load_tx;

  //////////////////////////////////////////////////////////////////////
  // edge and condition detection on the filtered levels

  // a level moves only once the second and third stages agree
  assign stable = ~(sync2 ^ sync3);
  assign next_lvl = (stable & sync3) | (~stable & lvl);

  // [R16] edges of the filtered scl
  assign scl_rise = stable[1] & sync3[1] & ~lvl[1];
  assign scl_fall = stable[1] & ~sync3[1] & lvl[1];

  // sda moving while scl is high marks start and stop
  assign bus_start = stable[0] & ~sync3[0] & lvl[0] & lvl[1];
  assign bus_stop = stable[0] & sync3[0] & ~lvl[0] & lvl[1];

  // incoming bit is the sda level held during scl high
  assign rx_byte = {shift[6:0], lvl[0]};
  assign mem_byte = mem[addr_cnt];

  // [R11] type code and strapped select must both match
  assign cs_ok = (rx_byte[7:4] == eeprom_rd_pkg::DEV_TYPE_CODE) &&
                 (rx_byte[3:1] == lvl[4:2]);

  //////////////////////////////////////////////////////////////////////
  // protocol sequencer

  always_comb begin
    next_state = state;
    next_ret = ret;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_addr_cnt = addr_cnt;
    next_addr_hi = addr_hi;
    next_drive = drive;
    load_tx = 1'b0;
    case (state)
      st_addr, st_whi, st_wlo: begin
        // [R16] shift in on scl rising edges
        if (scl_rise) begin
          next_shift = rx_byte;
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == eeprom_rd_pkg::BIT_LAST) begin
            next_bit_cnt = 4'h0;
            next_state = st_ack;
            if (state == st_addr) begin
              // [R1] read word goes on to stream data
              next_ret = rx_byte[0] ? st_tx : st_whi;
              // [R11] no match: back to standby, no ack
              if (!cs_ok) begin
                next_state = st_idle;
              end
            end else if (state == st_whi) begin
              // [R14] high address byte, acked like any other
              next_addr_hi = rx_byte;
              next_ret = st_wlo;
            end else begin
              // [R8] word address lands in the counter
              // [R13] [R15] only the low twelve bits are kept
              next_addr_cnt = ADDR_W'({addr_hi, rx_byte});
              // write data after this is neither acked nor stored
              next_ret = st_idle;
            end
          end
        end
      end
      st_ack: begin
        // [R1] pull low for the whole ninth clock
        if (scl_fall) begin
          if (!drive) begin
            next_drive = 1'b1;
          end else begin
            next_drive = 1'b0;
            next_state = ret;
            if (ret == st_tx) begin
              load_tx = 1'b1;
            end
          end
        end
      end
      st_tx: begin
        // [R16] next data bit goes out after each falling edge
        if (scl_fall) begin
          if (bit_cnt == eeprom_rd_pkg::BIT_LAST) begin
            // [R15] hand the ack slot to the controller
            next_drive = 1'b0;
            next_state = st_hack;
          end else begin
            next_bit_cnt = bit_cnt + 4'h1;
            next_shift = {shift[6:0], 1'b0};
            next_drive = ~shift[6];
          end
        end
      end
      st_hack: begin
        // [R3] [R4] controller ack asks for another byte
        if (scl_rise) begin
          if (lvl[0]) begin
            // [R6] nack ends streaming; wait for the stop
            next_state = st_idle;
          end else begin
            next_bit_cnt = 4'h0;
          end
        end else if (scl_fall && bit_cnt == 4'h0) begin
          load_tx = 1'b1;
        end
      end
      st_idle: begin
        next_drive = 1'b0;
      end
      default: begin
        next_state = st_idle;
        next_drive = 1'b0;
      end
    endcase

    // [R2] fetch a byte, msb first, then bump the counter
    if (load_tx) begin
      next_shift = mem_byte;
      next_drive = ~mem_byte[7];
      next_bit_cnt = 4'h0;
      // [R5] plain binary carry wraps the top address to zero
      next_addr_cnt = addr_cnt + 1'b1;
      next_state = st_tx;
    end

    // [R10] a start drops whatever was pending, counter kept
    if (bus_start) begin
      next_state = st_addr;
      next_bit_cnt = 4'h0;
      next_drive = 1'b0;
    end else if (bus_stop) begin
      // [R15] stop always lands in standby with sda released
      next_state = st_idle;
      next_drive = 1'b0;
    end
  end

  // [R12] counter only moves by access, never cleared by a stop
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1 <= eeprom_rd_pkg::TGT_LVL_RESET;
      sync2 <= eeprom_rd_pkg::TGT_LVL_RESET;
      sync3 <= eeprom_rd_pkg::TGT_LVL_RESET;
      lvl <= eeprom_rd_pkg::TGT_LVL_RESET;
      state <= st_idle;
      ret <= st_idle;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      addr_cnt <= ADDR_W'(eeprom_rd_pkg::ADDR_CNT_RESET);
      addr_hi <= 8'h00;
      drive <= 1'b0;
    end else if (ce_i) begin
      sync1 <= {chip_select_address_pins_i, link.scl, link.sda};
      sync2 <= sync1;
      sync3 <= sync2;
      lvl <= next_lvl;
      state <= next_state;
      ret <= next_ret;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      addr_cnt <= next_addr_cnt;
      addr_hi <= next_addr_hi;
      drive <= next_drive;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // array fill port; no reset, contents are whatever was loaded

  always_ff @(posedge clk_sys_i) begin
    if (ce_i && load_en_i) begin
      mem[load_addr_i] <= load_data_i;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  // open drain: the pin is only ever pulled low
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = drive;
  assign addr_cnt_o = addr_cnt;
  assign active_o = (state != st_idle);

endmodule

// File: test/eeprom_link_chk.sv
// link checker for the read-side eeprom target and its controller
// assumes one controller, a pull-up on sda and straps equal to CS
`timescale 1ns/10ps
module eeprom_link_chk #(
  parameter logic [2:0] CS = 3'h0
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe
);
  logic scl_q, next_scl_q, sda_q, next_sda_q;
  logic [3:0] bcnt, next_bcnt, lo_cnt, next_lo_cnt;
  logic [1:0] byte_idx, next_byte_idx;
  logic [7:0] sh, next_sh;
  logic rd, next_rd, wr, next_wr;
  logic rise, start, stop, match;

  //////////////////////////////////////////////////////////////////////
  // raw pin events; start and stop need scl high on both samples
  assign rise = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop = scl & scl_q & ~sda_q & sda;
  assign match = (sh[7:4] == eeprom_rd_pkg::DEV_TYPE_CODE) && (sh[3:1] == CS);

  // bit and byte tracking, address byte decides the mode
  always_comb begin
    next_scl_q = scl;
    next_sda_q = sda;
    next_bcnt = bcnt;
    next_byte_idx = byte_idx;
    next_sh = sh;
    next_rd = rd;
    next_wr = wr;
    next_lo_cnt = scl ? 4'h0 : ((lo_cnt == 4'hF) ? lo_cnt : lo_cnt + 4'h1);
    if (start) begin
      next_bcnt = 4'h0;
      next_byte_idx = 2'h0;
    end else if (rise && bcnt == 4'h8) begin
      next_bcnt = 4'h0;
      next_byte_idx = (byte_idx == 2'h3) ? byte_idx : byte_idx + 2'h1;
      if (byte_idx == 2'h0) begin
        next_rd = match & sh[0];
        next_wr = match & ~sh[0];
      end
    end else if (rise) begin
      next_bcnt = bcnt + 4'h1;
      next_sh = {sh[6:0], sda};
    end
  end

  // registers only; idle bus after reset so no false start
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bcnt <= 4'h0;
      byte_idx <= 2'h0;
      sh <= 8'h00;
      rd <= 1'b0;
      wr <= 1'b0;
      lo_cnt <= 4'h0;
    end else begin
      scl_q <= next_scl_q;
      sda_q <= next_sda_q;
      bcnt <= next_bcnt;
      byte_idx <= next_byte_idx;
      sh <= next_sh;
      rd <= next_rd;
      wr <= next_wr;
      lo_cnt <= next_lo_cnt;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  //////////////////////////////////////////////////////////////////////
  // the ninth rise of a byte carries the acknowledge
  sequence s_ninth;
    rise && bcnt == 4'h8;
  endsequence
  sequence s_data_bit;
    rise && rd && byte_idx != 2'h0 && bcnt < 4'h8;
  endsequence

  property p_addr_ack;
    s_ninth ##0 (byte_idx == 2'h0 && match) |-> !sda;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("matching address not acknowledged");
  property p_addr_noack;
    s_ninth ##0 (byte_idx == 2'h0 && !match) |-> sda;
  endproperty
  a_addr_noack: assert property (p_addr_noack)
    else $error("foreign address acknowledged");
  property p_word_ack;
    s_ninth ##0 (wr && byte_idx != 2'h0 && byte_idx != 2'h3) |-> !sda;
  endproperty
  a_word_ack: assert property (p_word_ack)
    else $error("word address byte not acknowledged");
  property p_host_slot;
    s_ninth ##0 (rd && byte_idx != 2'h0) |-> !dev_sda_oe;
  endproperty
  a_host_slot: assert property (p_host_slot)
    else $error("target drives sda in controller ack slot");
  property p_addr_quiet;
    rise && byte_idx == 2'h0 && bcnt < 4'h8 |-> !dev_sda_oe;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("target drives sda during address bits");
  property p_data_hold;
    s_data_bit |-> $stable(sda) [*6];
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("read data moved while scl high");
  property p_oe_timing;
    $changed(dev_sda_oe) |-> !scl && lo_cnt >= 4'h3 && lo_cnt <= 4'h6;
  endproperty
  a_oe_timing: assert property (p_oe_timing)
    else $error("target sda drive changed off the scl fall");
  property p_stop_idle;
    stop |=> !dev_sda_oe [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("target drives sda after stop");

  c_data: cover property (s_data_bit);
endmodule

// File: test/serial_eeprom_read_ops_bench.sv
// bench: eeprom target and controller joined by one link
// assumes the design package and link interface are compiled first
`timescale 1ns/10ps
module serial_eeprom_read_ops_bench;
  localparam int QC = 8;
  localparam logic [2:0] CS_PINS = 3'h5;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req = 1'b0;
  logic random = 1'b0;
  logic load_en = 1'b0;
  logic [11:0] word_addr = 12'h000;
  logic [11:0] load_addr = 12'h000;
  logic [2:0] dev_sel = 3'h0;
  logic [7:0] count = 8'h00;
  logic [7:0] load_data = 8'h00;
  logic [7:0] rd_data;
  logic busy, rd_valid, done, nack, active;
  logic [11:0] addr_cnt;
  int failures = 0;
  int tests_run = 0;

  ee_link_if ee_link_if_inst();
  eeprom_read_target eeprom_read_target_inst (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .ce_i(1'b1), .chip_select_address_pins_i(CS_PINS),
    .load_en_i(load_en), .load_addr_i(load_addr), .load_data_i(load_data),
    .addr_cnt_o(addr_cnt), .active_o(active),
    .link(ee_link_if_inst.target));
  eeprom_read_controller #(.QUARTER_CYC(QC)) eeprom_read_controller_inst (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1), .req_i(req),
    .random_i(random), .word_addr_i(word_addr), .dev_sel_i(dev_sel),
    .count_i(count), .busy_o(busy), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .done_o(done), .nack_o(nack),
    .link(ee_link_if_inst.controller));
  eeprom_link_chk #(.CS(CS_PINS)) eeprom_link_chk_inst (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .scl(ee_link_if_inst.scl), .sda(ee_link_if_inst.sda),
    .dev_sda_oe(ee_link_if_inst.dev_sda_oe));

  //////////////////////////////////////////////////////////////////////
  // 100 MHz system clock
  always #5 clk_sys_i = ~clk_sys_i;

  // array pattern mixes high bits in so wrap errors show
  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction

  task automatic check(input string what, input logic [11:0] exp,
                       input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one request; bytes judged as they arrive, bounded wait for done
  task automatic do_read(input logic rnd, input logic [11:0] a,
                         input logic [2:0] sel, input int n, input int exp_n,
                         input logic [11:0] first);
    int got;
    int wait_cyc;
    got = 0;
    wait_cyc = 0;
    @(negedge clk_sys_i);
    req = 1'b1;
    random = rnd;
    word_addr = a;
    dev_sel = sel;
    count = n[7:0];
    @(negedge clk_sys_i);
    req = 1'b0;
    check("busy after take", 12'h001, {11'h000, busy});
    while (done !== 1'b1 && wait_cyc < 20000) begin
      @(posedge clk_sys_i);
      #1;
      if (rd_valid === 1'b1) begin
        check("read byte", {4'h0, pat(first + got[11:0])},
              {4'h0, rd_data});
        got++;
      end
      wait_cyc++;
    end
    check("done seen", 12'h001, {11'h000, done});
    check("busy after done", 12'h000, {11'h000, busy});
    check("byte count", exp_n[11:0], got[11:0]);
    check("nack flag", {11'h000, exp_n == 0}, {11'h000, nack});
    @(negedge clk_sys_i);
    check("target standby", 12'h000, {11'h000, active});
  endtask

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_random_wrap;
    do_read(1'b1, 12'hFFE, CS_PINS, 4, 4, 12'hFFE);
    check("counter after wrap", 12'h002, addr_cnt);
  endtask

  task automatic t_current;
    // a count of zero still fetches exactly one byte
    do_read(1'b0, 12'h000, CS_PINS, 0, 1, 12'h002);
    check("counter after current", 12'h003, addr_cnt);
  endtask

  task automatic t_bad_select;
    do_read(1'b1, 12'h7AB, 3'h2, 1, 0, 12'h000);
    check("counter kept", 12'h003, addr_cnt);
  endtask

  task automatic t_restart_stream;
    do_read(1'b1, 12'h123, CS_PINS, 1, 1, 12'h123);
    do_read(1'b0, 12'h000, CS_PINS, 3, 3, 12'h124);
    check("counter after stream", 12'h127, addr_cnt);
  endtask

  //////////////////////////////////////////////////////////////////////
  // reset, fill the array, then the scenarios
  initial begin
    repeat (16) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    for (int a = 0; a < 4096; a++) begin
      @(negedge clk_sys_i);
      load_en = 1'b1;
      load_addr = a[11:0];
      load_data = pat(a[11:0]);
    end
    @(negedge clk_sys_i);
    load_en = 1'b0;
    t_random_wrap();
    t_current();
    t_bad_select();
    t_restart_stream();
    give_verdict();
  end

  // watchdog: whole run needs well under 20000 cycles
  initial begin
    #500000;
    failures++;
    $display("BAD watchdog expected finish seen hang");
    give_verdict();
  end
endmodule
